// ---- rtc_tb_pkg.sv ----
package rtc_tb_pkg;

    // System clock rate
    localparam int CLK_MHZ = 250;

    // Crystal-valid blanking after power-on, in ms
    localparam int BLANK_MS = 2;
    localparam int BLANK_CYCLES = BLANK_MS * 1000 * CLK_MHZ;

    // Missing-clock limit, in us
    localparam int MISS_US = 100;
    localparam int MISS_CYCLES = MISS_US * CLK_MHZ;

    // Dwell per load-capacitance step, in us
    localparam int STEP_US = 500;
    localparam int STEP_CYCLES = STEP_US * CLK_MHZ;

    // Width of the long cycle counters
    localparam int CNT_W = 20;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_LOADCFG = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_INT_STAT = 8'h0c;
    localparam logic [7:0] OFS_INT_MASK = 8'h10;
    localparam logic [7:0] OFS_TIMER = 8'h14;

    // Control register bit positions
    localparam int CTL_XTAL = 0;
    localparam int CTL_GAIN = 1;
    localparam int CTL_BIAS2 = 2;
    localparam int CTL_POWER = 3;
    localparam int CTL_SLOW = 4;
    localparam int CTL_MISS = 5;
    localparam int CTL_AUTOSTEP = 6;
    localparam int CTL_RUN = 7;

    // Status register bit positions
    localparam int ST_VALID = 0;
    localparam int ST_READY = 1;
    localparam int ST_FAIL = 2;
    localparam int ST_CODE_LSB = 4;
    localparam int ST_PF_LSB = 8;

    // Interrupt status bit positions
    localparam int IRQ_FAIL = 0;
    localparam int IRQ_READY = 1;
    localparam int IRQ_VALID = 2;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] CAP_RST = 4'h0;
    localparam logic [2:0] IRQ_RST = 3'h0;

    // Capacitance code breakpoint and base values in tenths of a pF
    localparam logic [3:0] CAP_COARSE = 4'hc;
    localparam logic [7:0] CAP_FINE_BASE = 8'h28;
    localparam logic [7:0] CAP_COARSE_BASE = 8'h69;

    // Load capacitance of a code, in tenths of a pF
    function automatic logic [7:0] cap_tenths(input logic [3:0] code);
        logic [7:0] c;
        c = {4'h0, code};
        if (code < CAP_COARSE) begin
            cap_tenths = CAP_FINE_BASE + 8'(c * 8'h05);
        end else begin
            cap_tenths = CAP_COARSE_BASE + 8'((c - 8'h0c) * 8'h0a);
        end
    endfunction : cap_tenths

endpackage : rtc_tb_pkg

// ---- load_cap_stepper.sv ----
`timescale 1ns/10ps
`default_nettype none
module load_cap_stepper
    import rtc_tb_pkg::*;
#(
    parameter int STEP_CNT = STEP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [3:0] wr_code,
    input wire logic autostep,
    output logic [3:0] applied,
    output logic ready
);
    logic [3:0] target_ff, nxt_target;     // Programmed final code
    logic [3:0] applied_ff, nxt_applied;   // Code driven to the capacitor bank
    logic ready_ff, nxt_ready;             // Applied code has reached target
    logic [CNT_W-1:0] dwell_ff, nxt_dwell; // Cycles spent on the present step

    // Next-state: a write restarts from the smallest code when stepping
    always_comb begin
        nxt_target = target_ff;
        nxt_applied = applied_ff;
        nxt_dwell = dwell_ff;
        nxt_ready = (applied_ff == target_ff); // [R12]
        if (wr_en) begin
            nxt_target = wr_code;
            nxt_applied = autostep ? CAP_RST : wr_code; // [R11]
            nxt_dwell = '0;
            nxt_ready = 1'b0; // [R16]
        end else if (applied_ff != target_ff) begin
            // Without stepping the target is applied at once
            if (!autostep) begin
                nxt_applied = target_ff;
            end else if (dwell_ff == CNT_W'(STEP_CNT - 1)) begin
                // Slow rise keeps crystal start-up fast
                nxt_applied = applied_ff + 4'h1; // [R11]
                nxt_dwell = '0;
            end else begin
                nxt_dwell = dwell_ff + 1'b1;
            end
        end
    end

    // Registers, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            target_ff <= CAP_RST;
            applied_ff <= CAP_RST;
            ready_ff <= 1'b0;
            dwell_ff <= '0;
        end else if (ce) begin
            target_ff <= nxt_target;
            applied_ff <= nxt_applied;
            ready_ff <= nxt_ready;
            dwell_ff <= nxt_dwell;
        end
    end

    assign applied = applied_ff;
    assign ready = ready_ff;

    step_rise_a: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        ce && !wr_en && autostep && applied_ff != target_ff
        |=> applied_ff == $past(applied_ff) || applied_ff == $past(applied_ff) + 4'h1)
        else $error("load code jumped while stepping");
    ready_match_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        ce && !wr_en && applied_ff == target_ff |=> ready_ff)
        else $error("ready not set at target");
    ready_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
        ce && wr_en |=> !ready_ff)
        else $error("ready survived a new selection");

endmodule : load_cap_stepper
`default_nettype wire

// ---- missing_clock_detector.sv ----
`timescale 1ns/10ps
`default_nettype none
module missing_clock_detector
    import rtc_tb_pkg::*;
#(
    parameter int MISS_CNT = MISS_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic enable,
    input wire logic tb_level,
    output logic fail
);
    logic last_ff, nxt_last;              // Timebase level last seen
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;    // Cycles since last level change
    logic fired_ff, nxt_fired;            // One-shot: fire once per stall
    logic fail_ff, nxt_fail;              // Failure pulse

    // Next-state: any level change rearms the one-shot
    always_comb begin
        nxt_last = tb_level;
        nxt_cnt = cnt_ff;
        nxt_fired = fired_ff;
        nxt_fail = 1'b0;
        if (!enable || tb_level != last_ff) begin
            nxt_cnt = '0;
            nxt_fired = 1'b0;
        end else if (cnt_ff == CNT_W'(MISS_CNT)) begin
            // Held past the limit in either level
            nxt_fail = !fired_ff; // [R14]
            nxt_fired = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    // Registers, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_ff <= 1'b0;
            cnt_ff <= '0;
            fired_ff <= 1'b0;
            fail_ff <= 1'b0;
        end else if (ce) begin
            last_ff <= nxt_last;
            cnt_ff <= nxt_cnt;
            fired_ff <= nxt_fired;
            fail_ff <= nxt_fail;
        end
    end

    assign fail = fail_ff;

    fail_cause_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        $rose(fail_ff) |-> $past(enable) && $past(cnt_ff) == CNT_W'(MISS_CNT))
        else $error("failure flagged without a stall");

endmodule : missing_clock_detector
`default_nettype wire

// ---- rtc_timebase_source_control.sv ----
`timescale 1ns/10ps
`default_nettype none
// How it works
// [R1] Timer counts only timebase edges, not pclk
// [R2] Source: external clock, slow osc, oscillator
// [R3] Software crystal start sequence, then 20 ms
// [R4] Software polls flags, retunes, clears wake flags
// [R5] Failure flag confirms external clock after 2 ms
// [R6] Software uses lowest bias, no gain control
// [R7] Crystal mode off selects self-oscillate, bias sets rate
// [R8] Self-oscillate runs at once, no blanking
// [R9] Slow osc enable powers and selects it
// [R10] Slow osc steps timer by two
// [R11] Autostep rises from smallest to programmed code
// [R12] Ready set when applied reaches programmed code
// [R13] Sixteen codes map to documented capacitances
// [R14] Stuck timebase over 100 us flags failure
// [R15] Crystal valid blanked 2 ms after power-on
// [R16] New selection clears ready until reached
module rtc_timebase_source_control
    import rtc_tb_pkg::*;
#(
    parameter int BLANK_CNT = BLANK_CYCLES,
    parameter int MISS_CNT = MISS_CYCLES,
    parameter int STEP_CNT = STEP_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timebase_in,
    input wire logic amp_detect_in,
    output logic crystal_mode_select,
    output logic gain_control_enable,
    output logic bias_double,
    output logic osc_power_enable,
    output logic slow_osc_enable,
    output logic [3:0] load_cap_select,
    output logic irq
);
    // Synchronisers for the asynchronous timebase and amplitude detector
    logic tb_s1_ff, tb_s2_ff, tb_s3_ff;
    logic amp_s1_ff, amp_s2_ff;

    // Software-visible state
    logic [7:0] ctrl_ff, nxt_ctrl;          // Control bits
    logic [2:0] int_stat_ff, nxt_int_stat;  // Sticky event bits
    logic [2:0] int_mask_ff, nxt_int_mask;  // Interrupt enables
    logic [31:0] timer_ff, nxt_timer;       // Timebase counter
    logic [31:0] prdata_ff, nxt_prdata;     // Registered read data
    logic pslverr_ff, nxt_pslverr;          // Registered unmapped flag

    // Crystal blanking and edge history
    logic [CNT_W-1:0] blank_ff, nxt_blank;  // Remaining blanking cycles
    logic power_d_ff, nxt_power_d;          // Power enable one cycle ago
    logic valid_d_ff, nxt_valid_d;          // Valid flag one cycle ago
    logic ready_d_ff, nxt_ready_d;          // Ready flag one cycle ago

    logic wr_en;          // Completed APB write
    logic tb_rise;        // Rising edge of the timebase
    logic src_active;     // Some timebase source is running
    logic crystal_valid;  // Crystal-valid flag after blanking
    logic load_ready;     // Load capacitance at programmed code
    logic miss_fail;      // One-cycle missing-clock event
    logic [3:0] cap_code; // Code applied to the capacitor bank
    logic [7:0] cap_pf;   // Applied capacitance in tenths of a pF
    logic [2:0] events;   // Event pulses into the sticky bits

    // Two flops before any logic reads the pins; third flop for the edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tb_s1_ff <= 1'b0;
            tb_s2_ff <= 1'b0;
            tb_s3_ff <= 1'b0;
            amp_s1_ff <= 1'b0;
            amp_s2_ff <= 1'b0;
        end else if (ce) begin
            tb_s1_ff <= timebase_in;
            tb_s2_ff <= tb_s1_ff;
            tb_s3_ff <= tb_s2_ff;
            amp_s1_ff <= amp_detect_in;
            amp_s2_ff <= amp_s1_ff;
        end
    end

    // Slave always answers in the access cycle unless frozen
    assign pready = ce;
    assign wr_en = psel && penable && pwrite && ce;
    assign tb_rise = tb_s2_ff && !tb_s3_ff;

    // Either the slow osc or the powered oscillator drives the timer
    assign src_active = ctrl_ff[CTL_SLOW] || ctrl_ff[CTL_POWER]; // [R2] [R9]

    // Self-oscillate is valid at once; crystal waits out the blanking
    // The blanking load lands a cycle after power rises, so the delayed
    // power bit keeps that first cycle from reading as valid
    assign crystal_valid = ctrl_ff[CTL_POWER] && !ctrl_ff[CTL_SLOW]
        && (!ctrl_ff[CTL_XTAL] || (power_d_ff && blank_ff == '0 && amp_s2_ff)); // [R8] [R15]

    assign cap_pf = cap_tenths(cap_code); // [R13]

    // Capacitance stepping and ready flag
    load_cap_stepper #(
        .STEP_CNT(STEP_CNT)
    ) u_stepper (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .wr_en(wr_en && paddr == OFS_LOADCFG),
        .wr_code(pwdata[3:0]),
        .autostep(ctrl_ff[CTL_AUTOSTEP]),
        .applied(cap_code),
        .ready(load_ready)
    );

    // Stuck-timebase watchdog
    missing_clock_detector #(
        .MISS_CNT(MISS_CNT)
    ) u_miss (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .enable(ctrl_ff[CTL_MISS]),
        .tb_level(tb_s2_ff),
        .fail(miss_fail)
    );

    // Events: failure, ready reached, crystal becoming valid
    always_comb begin
        events = '0;
        events[IRQ_FAIL] = miss_fail; // [R14] [R5]
        events[IRQ_READY] = load_ready && !ready_d_ff;
        events[IRQ_VALID] = crystal_valid && !valid_d_ff;
    end

    // Next-state of the software-visible registers
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_int_mask = int_mask_ff;
        nxt_int_stat = int_stat_ff;
        if (wr_en && paddr == OFS_CTRL) begin
            nxt_ctrl = pwdata[7:0];
        end
        if (wr_en && paddr == OFS_INT_MASK) begin
            nxt_int_mask = pwdata[2:0];
        end
        // Write one clears; a same-cycle event still wins
        if (wr_en && paddr == OFS_INT_STAT) begin
            nxt_int_stat = int_stat_ff & ~pwdata[2:0];
        end
        nxt_int_stat = nxt_int_stat | events;
    end

    // Next-state of the timer and blanking counter
    always_comb begin
        nxt_timer = timer_ff;
        nxt_blank = blank_ff;
        nxt_power_d = ctrl_ff[CTL_POWER];
        nxt_valid_d = crystal_valid;
        nxt_ready_d = load_ready;
        // Only timebase edges advance it, so rate is pclk-independent
        if (ctrl_ff[CTL_RUN] && src_active && tb_rise) begin // [R1]
            // Slow osc runs near half rate, so count from bit 1
            if (ctrl_ff[CTL_SLOW]) begin
                nxt_timer = timer_ff + 32'h0000_0002; // [R10]
            end else begin
                nxt_timer = timer_ff + 32'h0000_0001;
            end
        end
        // Power-on restarts the blanking window
        if (ctrl_ff[CTL_POWER] && !power_d_ff) begin
            nxt_blank = CNT_W'(BLANK_CNT); // [R15]
        end else if (blank_ff != '0) begin
            nxt_blank = blank_ff - 1'b1;
        end
    end

    // Read data and error flag are prepared a cycle ahead
    always_comb begin
        nxt_prdata = '0;
        nxt_pslverr = 1'b0;
        unique case (paddr)
            OFS_CTRL: nxt_prdata[7:0] = ctrl_ff;
            OFS_LOADCFG: nxt_prdata[3:0] = cap_code;
            OFS_STATUS: begin
                nxt_prdata[ST_VALID] = crystal_valid;
                nxt_prdata[ST_READY] = load_ready;
                nxt_prdata[ST_FAIL] = int_stat_ff[IRQ_FAIL];
                nxt_prdata[ST_CODE_LSB +: 4] = cap_code;
                nxt_prdata[ST_PF_LSB +: 8] = cap_pf;
            end
            OFS_INT_STAT: nxt_prdata[2:0] = int_stat_ff;
            OFS_INT_MASK: nxt_prdata[2:0] = int_mask_ff;
            OFS_TIMER: nxt_prdata = timer_ff;
            default: nxt_pslverr = 1'b1;
        endcase
    end

    // Register all groups; nothing moves while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= CTRL_RST;
            int_stat_ff <= IRQ_RST;
            int_mask_ff <= IRQ_RST;
            timer_ff <= '0;
            blank_ff <= '0;
            power_d_ff <= 1'b0;
            valid_d_ff <= 1'b0;
            ready_d_ff <= 1'b0;
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
        end else if (ce) begin
            ctrl_ff <= nxt_ctrl;
            int_stat_ff <= nxt_int_stat;
            int_mask_ff <= nxt_int_mask;
            timer_ff <= nxt_timer;
            blank_ff <= nxt_blank;
            power_d_ff <= nxt_power_d;
            valid_d_ff <= nxt_valid_d;
            ready_d_ff <= nxt_ready_d;
            prdata_ff <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Oscillator controls come straight from the control register, the load code from the stepper
    assign crystal_mode_select = ctrl_ff[CTL_XTAL]; // [R7]
    assign gain_control_enable = ctrl_ff[CTL_GAIN];
    assign bias_double = ctrl_ff[CTL_BIAS2]; // [R7]
    assign osc_power_enable = ctrl_ff[CTL_POWER];
    assign slow_osc_enable = ctrl_ff[CTL_SLOW]; // [R9]
    assign load_cap_select = cap_code;
    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff && psel && penable;
    assign irq = |(int_stat_ff & int_mask_ff);

    timer_double_a: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        ce && ctrl_ff[CTL_RUN] && ctrl_ff[CTL_SLOW] && tb_rise
        |=> timer_ff == $past(timer_ff) + 32'h0000_0002)
        else $error("slow osc did not step timer by two");
    timer_single_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        ce && ctrl_ff[CTL_RUN] && ctrl_ff[CTL_POWER] && !ctrl_ff[CTL_SLOW] && tb_rise
        |=> timer_ff == $past(timer_ff) + 32'h0000_0001)
        else $error("oscillator did not step timer by one");
    timer_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        ce && !tb_rise |=> $stable(timer_ff))
        else $error("timer moved without a timebase edge");
    blank_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        ctrl_ff[CTL_XTAL] && (blank_ff != '0 || !power_d_ff) |-> !crystal_valid)
        else $error("crystal valid inside blanking");
    self_valid_a: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        ctrl_ff[CTL_POWER] && !ctrl_ff[CTL_XTAL] && !ctrl_ff[CTL_SLOW] |-> crystal_valid)
        else $error("self-oscillate not valid at once");
    fail_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        ce && miss_fail |=> int_stat_ff[IRQ_FAIL])
        else $error("failure event lost");
    irq_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(irq) |-> $past(ce) && |$past(events | int_stat_ff))
        else $error("interrupt without an event");

    // Event and sticky-bit checks
    ready_event_a: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        ce && load_ready && !ready_d_ff |=> int_stat_ff[IRQ_READY])
        else $error("ready event lost");

    valid_event_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && crystal_valid && !valid_d_ff |=> int_stat_ff[IRQ_VALID])
        else $error("valid event lost");

    // Only a write of one may drop a sticky bit
    stat_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !(wr_en && paddr == OFS_INT_STAT)
        |=> (int_stat_ff & $past(int_stat_ff)) == $past(int_stat_ff))
        else $error("status bit dropped");

    // Power-on must restart the blanking window
    blank_load_a: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        ce && ctrl_ff[CTL_POWER] && !power_d_ff |=> blank_ff == CNT_W'(BLANK_CNT))
        else $error("blanking not restarted");

    // Register writes land, unmapped ones are dropped
    ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        wr_en && paddr == OFS_CTRL |=> ctrl_ff == $past(pwdata[7:0]))
        else $error("control write lost");

    write_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && pslverr |=> $stable(ctrl_ff) && $stable(int_mask_ff))
        else $error("unmapped write landed");

    slow_select_a: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        ctrl_ff[CTL_SLOW] |-> slow_osc_enable && !crystal_valid)
        else $error("slow osc not selected");

endmodule : rtc_timebase_source_control
`default_nettype wire

// ---- test_rtc_timebase_source_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_rtc_timebase_source_control;
    import rtc_tb_pkg::*;
    localparam int BLANK_T = 50; // Short blanking so the run stays brief
    localparam int MISS_T = 20; // Short missing-clock limit
    localparam int STEP_T = 4; // Short dwell per capacitance step
    localparam int LIMIT = 30000; // Cycle ceiling for the whole run
    logic pclk, presetn, ce, psel, penable, pwrite, timebase_in, amp_detect_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, t0;
    logic pready, pslverr, err, irq;
    logic crystal_mode_select, gain_control_enable, bias_double;
    logic osc_power_enable, slow_osc_enable;
    logic [3:0] load_cap_select, prev;
    int fails, comparisons, cycles, n;

    // Device under test with shortened counts
    rtc_timebase_source_control #(.BLANK_CNT(BLANK_T), .MISS_CNT(MISS_T),
        .STEP_CNT(STEP_T)) dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .timebase_in, .amp_detect_in,
        .crystal_mode_select, .gain_control_enable, .bias_double, .osc_power_enable,
        .slow_osc_enable, .load_cap_select, .irq);

    // Free-running system clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Hang guard: a stuck wait still reaches the verdict
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails++;
            conclude();
        end
    end

    // Verdict and end of run
    task automatic conclude();
        $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; data taken at the edge where pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Let cycles pass, then sample settled outputs
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask : tick

    // Timebase pulses: high for hi cycles, low for four
    task automatic pulses(input int k, input int hi);
        repeat (k) begin
            @(posedge pclk);
            timebase_in <= 1'b1;
            repeat (hi) @(posedge pclk);
            timebase_in <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask : pulses

    // Expected capacitance in tenths of a pF, worked out independently
    function automatic logic [7:0] pf(input int c);
        return (c < 12) ? CAP_FINE_BASE + 8'(c * 5) : CAP_COARSE_BASE + 8'((c - 12) * 10);
    endfunction : pf

    // Reset values and an unmapped address
    task automatic t_reset();
        check({crystal_mode_select, gain_control_enable, bias_double, osc_power_enable}, 0);
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, {24'h0, CTRL_RST});
        apb(1'b1, 8'h40, 32'hff);
        check(err, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h0);
        $display("test reset done");
    endtask : t_reset

    // Every capacitance code, stepping off
    task automatic t_cap();
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, OFS_LOADCFG, 32'(c));
            tick(3);
            check(load_cap_select, c[3:0]);
            apb(1'b0, OFS_STATUS, 32'h0);
            check(rd[15:4], {pf(c), c[3:0]});
            check(rd[ST_READY], 1'b1);
        end
        $display("test cap done");
    endtask : t_cap

    // Automatic stepping from zero, ready event and interrupt masking
    task automatic t_step();
        apb(1'b1, OFS_CTRL, 32'h40);
        apb(1'b1, OFS_INT_STAT, 32'h7);
        apb(1'b1, OFS_INT_MASK, 32'h2);
        apb(1'b1, OFS_LOADCFG, 32'h9);
        tick(1);
        check(load_cap_select, 4'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[ST_READY], 1'b0);
        prev = load_cap_select;
        n = 0;
        // One step at a time, never past the target, no early ready
        while (load_cap_select !== 4'h9 && n < 200) begin
            tick(1);
            n++;
            check(irq, 1'b0);
            if (load_cap_select !== prev) begin
                check(load_cap_select, prev + 4'h1);
                prev = load_cap_select;
            end
        end
        check(32'(n >= 7 * STEP_T), 32'h1);
        tick(3);
        check(irq, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[ST_READY], 1'b1);
        apb(1'b1, OFS_INT_MASK, 32'h0);
        tick(1);
        check(irq, 1'b0);
        apb(1'b1, OFS_INT_MASK, 32'h2);
        apb(1'b1, OFS_INT_STAT, 32'h2);
        tick(2);
        check(irq, 1'b0);
        $display("test step done");
    endtask : t_step

    // Crystal start-up sequence, blanking, then self-oscillate
    task automatic t_xtal();
        @(posedge pclk);
        amp_detect_in <= 1'b1;
        apb(1'b1, OFS_CTRL, 32'h05);
        apb(1'b1, OFS_CTRL, 32'h0d);
        tick(2);
        check({crystal_mode_select, gain_control_enable, bias_double, osc_power_enable},
            4'hb);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[ST_VALID], 1'b0);
        apb(1'b0, OFS_INT_STAT, 32'h0);
        check(rd[IRQ_VALID], 1'b0);
        tick(BLANK_T);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[ST_VALID], 1'b1);
        apb(1'b1, OFS_CTRL, 32'h0b);
        tick(1);
        check({gain_control_enable, bias_double}, 2'h2);
        // Self-oscillate: valid at once, whatever the detector says
        apb(1'b1, OFS_CTRL, 32'h0);
        amp_detect_in <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h0c);
        tick(2);
        check({crystal_mode_select, bias_double, osc_power_enable}, 3'h3);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[ST_VALID], 1'b1);
        $display("test xtal done");
    endtask : t_xtal

    // Missing clock with an external clock: gaps just short, then a stall
    task automatic t_miss();
        apb(1'b1, OFS_CTRL, 32'h29);
        apb(1'b1, OFS_INT_STAT, 32'h7);
        pulses(4, 4);
        pulses(2, MISS_T - 4);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[ST_FAIL], 1'b0);
        tick(MISS_T + 8);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(rd[ST_FAIL], 1'b1);
        apb(1'b0, OFS_INT_STAT, 32'h0);
        check(rd[IRQ_FAIL], 1'b1);
        apb(1'b1, OFS_INT_STAT, 32'h7);
        apb(1'b1, OFS_CTRL, 32'h0);
        $display("test miss done");
    endtask : t_miss

    // Timer counts timebase edges only; slow oscillator counts by two
    task automatic t_timer();
        apb(1'b1, OFS_CTRL, 32'h88);
        apb(1'b0, OFS_TIMER, 32'h0);
        t0 = rd;
        pulses(5, 4);
        tick(20);
        apb(1'b0, OFS_TIMER, 32'h0);
        check(rd - t0, 32'h5);
        apb(1'b1, OFS_CTRL, 32'h90);
        tick(2);
        check({slow_osc_enable, osc_power_enable}, 2'h2);
        apb(1'b0, OFS_TIMER, 32'h0);
        t0 = rd;
        pulses(5, 4);
        tick(20);
        apb(1'b0, OFS_TIMER, 32'h0);
        check(rd - t0, 32'ha);
        // Clock enable low: pready waits and timebase edges go unseen
        ce <= 1'b0;
        pulses(2, 4);
        check(pready, 1'b0);
        ce <= 1'b1;
        tick(4);
        apb(1'b0, OFS_TIMER, 32'h0);
        check(rd - t0, 32'ha);
        $display("test timer done");
    endtask : t_timer

    // Main sequence
    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        timebase_in = 1'b0;
        amp_detect_in = 1'b0;
        fails = 0;
        comparisons = 0;
        cycles = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        t_reset();
        t_cap();
        t_step();
        t_xtal();
        t_miss();
        t_timer();
        conclude();
    end
endmodule : test_rtc_timebase_source_control
`default_nettype wire
